// ---- rtl/tct_pkg.sv ----
// Purpose: Constants and carrier types for the TDM channel code translation block
// Assumes: One 125 MHz core clock; byte-level channel traffic from the switch core
// Notes:   Overview list of behaviour follows
//
// Overview of operation
// (RL1) Translate every output channel, switched or message sourced
// (RL2) Upper entry bit 4 picks voice or data
// (RL3) Bits 3:2 input law, bits 1:0 output law
// (RL4) Voice laws: A, mu, A plain, mu plain
// (RL5) Plain A-law skips even bit inversion
// (RL6) Plain mu-law skips magnitude inversion
// (RL7) Data code 00 inverts nothing
// (RL8) Data code 01 inverts bits 6,4,2,0
// (RL9) Data code 10 inverts bits 7,5,3,1
// (RL10) Data code 11 inverts all eight bits
// (RL11) Different laws convert, equal laws pass unchanged
// (RL12) Never convert between voice and data
// (RL13) Frame splits into four equal channel quadrants
// (RL14) Quadrant control fields in stream quadrant register
// (RL15) 0xx untouched, 100/101 force LSB 0/1
// (RL16) 110/111 force MSB 0/1
// (RL17) Software avoids quadrant replace with BER receiver
// (RL18) Upper entry writes use D4-0, reads zero-fill
// (RL19) Convert laws through companding, inversions around it
// (RL20) Quadrant replace applies at data memory write
package tct_pkg;

	// Register map of the stream input quadrant control block
	localparam logic [13:0] QUAD_BASE_ADDR  = 14'h0120;
	localparam logic [13:0] QUAD_LAST_ADDR  = 14'h012f;
	localparam logic [11:0] QUAD_RESET      = 12'h000;
	localparam int          QUAD_FIELD_W    = 3;
	localparam int          QUAD_REG_W      = 12;
	localparam int          STREAMS         = 16;

	// Connection memory upper entry layout
	localparam int          CM_DEPTH        = 1024;
	localparam int          CM_VD_BIT       = 4;
	localparam int          CM_ICL_LO       = 2;
	localparam int          CM_OCL_LO       = 0;

	// Law codes
	localparam logic [1:0]  LAW_A_STD       = 2'h0;
	localparam logic [1:0]  LAW_MU_STD      = 2'h1;
	localparam logic [1:0]  LAW_A_PLAIN     = 2'h2;
	localparam logic [1:0]  LAW_MU_PLAIN    = 2'h3;

	// Inversion masks
	localparam logic [7:0]  MASK_NONE       = 8'h00;
	localparam logic [7:0]  MASK_EVEN       = 8'h55;
	localparam logic [7:0]  MASK_ODD        = 8'haa;
	localparam logic [7:0]  MASK_ALL        = 8'hff;

	// Quadrant replacement codes
	localparam logic [2:0]  QR_LSB0         = 3'h4;
	localparam logic [2:0]  QR_LSB1         = 3'h5;
	localparam logic [2:0]  QR_MSB0         = 3'h6;
	localparam logic [2:0]  QR_MSB1         = 3'h7;

	// Companding constants
	localparam logic [15:0] MU_BIAS16       = 16'h0084;
	localparam logic [15:0] MU_BIAS14       = 16'h0021;
	localparam logic [15:0] MU_CLIP14       = 16'h1fff;
	localparam logic [15:0] A_SEG_END0      = 16'h001f;
	localparam logic [15:0] MU_SEG_END0     = 16'h003f;

	typedef struct packed {
		logic        valid;
		logic [3:0]  stream;
		logic [7:0]  channel;
		logic [1:0]  rate;
		logic [7:0]  data;
	} tct_in_s;

	typedef struct packed {
		logic        valid;
		logic [9:0]  channel;
		logic [7:0]  data;
	} tct_out_s;

	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [13:0] addr;
		logic [15:0] wrData;
	} tct_reg_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [9:0]  addr;
		logic [15:0] wrData;
	} tct_cm_s;

endpackage

// ---- rtl/tct_translate.sv ----
// Purpose: Quadrant bit replacement on input bytes and law translation on output bytes
// Assumes: Byte traffic arrives synchronous to core_clk; clkEn freezes all state
// Notes:   Results appear one enabled cycle after the request
module tct_translate (
	// Clock and reset
	input  wire logic            core_clk,
	input  wire logic            reset,
	input  wire logic            clkEn,
	// Register port
	input  wire tct_pkg::tct_reg_s regReq,
	output logic [15:0]          regRdData_q,
	// Connection memory upper entry port
	input  wire tct_pkg::tct_cm_s  cmReq,
	output logic [15:0]          cmRdData_q,
	// Input channel path
	input  wire tct_pkg::tct_in_s  inReq,
	output tct_pkg::tct_in_s       inRes_q,
	// Output channel path
	input  wire tct_pkg::tct_out_s outReq,
	output tct_pkg::tct_out_s      outRes_q
);

	typedef logic [tct_pkg::QUAD_REG_W-1:0] tct_quad_t;

	typedef struct packed {
		tct_quad_t [tct_pkg::STREAMS-1:0] quad;
		logic [15:0]                      regRd;
		logic [15:0]                      cmRd;
		tct_pkg::tct_in_s                 inRes;
		tct_pkg::tct_out_s                outRes;
	} tct_state_s;

	tct_state_s state_q;
	tct_state_s state_d;
	logic [4:0] cmMem [tct_pkg::CM_DEPTH];
	logic [4:0] cmEntry;

	// Inversion mask of a data law code
	function automatic logic [7:0] dataMask(input logic [1:0] law);
		logic [7:0] m;
		unique case (law)
			2'h0: m = tct_pkg::MASK_NONE;       // [RL7]
			2'h1: m = tct_pkg::MASK_EVEN;       // [RL8]
			2'h2: m = tct_pkg::MASK_ODD;        // [RL9]
			2'h3: m = tct_pkg::MASK_ALL;        // [RL10]
		endcase
		return m;
	endfunction

	// Quadrant register address hit
	function automatic logic quadHit(input logic [13:0] a);
		return (a >= tct_pkg::QUAD_BASE_ADDR) && (a <= tct_pkg::QUAD_LAST_ADDR);
	endfunction

	// A-law true code (sign 1 = positive) to 16-bit magnitude
	function automatic logic [15:0] aMag(input logic [7:0] t);
		logic [15:0] v;
		v = {8'h00, t[3:0], 4'h8};
		if (t[6:4] != 3'h0) begin
			v = 16'((v + 16'h0100) << (t[6:4] - 3'h1));
		end
		return v;
	endfunction

	// Mu-law true code (sign 1 = negative) to 16-bit magnitude
	function automatic logic [15:0] muMag(input logic [7:0] n);
		logic [15:0] v;
		v = 16'(({9'h000, n[3:0], 3'h0} + tct_pkg::MU_BIAS16) << n[6:4]);
		return 16'(v - tct_pkg::MU_BIAS16);
	endfunction

	// 16-bit magnitude to A-law segment and mantissa
	function automatic logic [6:0] aEnc(input logic [15:0] mag);
		logic [15:0] p;
		logic [3:0]  seg;
		logic [15:0] sh;
		p = mag >> 3;
		seg = 4'h0;
		sh = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (p > 16'(tct_pkg::A_SEG_END0 << i)) begin
				seg = 4'(i + 1);
			end
		end
		if (seg == 4'h8) begin
			return 7'h7f;
		end
		if (seg < 4'h2) begin
			sh = p >> 1;
		end else begin
			sh = p >> seg;
		end
		return {seg[2:0], sh[3:0]};
	endfunction

	// 16-bit magnitude to mu-law segment and mantissa
	function automatic logic [6:0] muEnc(input logic [15:0] mag);
		logic [15:0] p;
		logic [3:0]  seg;
		logic [15:0] sh;
		p = 16'((mag >> 2) + tct_pkg::MU_BIAS14);
		if (p > tct_pkg::MU_CLIP14) begin
			p = tct_pkg::MU_CLIP14;
		end
		seg = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (p > 16'(tct_pkg::MU_SEG_END0 << i)) begin
				seg = 4'(i + 1);
			end
		end
		if (seg == 4'h8) begin
			return 7'h7f;
		end
		sh = p >> (seg + 4'h1);
		return {seg[2:0], sh[3:0]};
	endfunction

	// Whole output channel translation
	function automatic logic [7:0] xlate(input logic [7:0] b, input logic [4:0] e);
		logic [1:0]  il;
		logic [1:0]  ol;
		logic        inMu;
		logic        outMu;
		logic        neg;
		logic [7:0]  t;
		logic [6:0]  code;
		logic [15:0] mag;
		logic [7:0]  r;
		il = e[tct_pkg::CM_ICL_LO +: 2];                      // [RL3]
		ol = e[tct_pkg::CM_OCL_LO +: 2];                      // [RL3]
		inMu = il[0];
		outMu = ol[0];
		t = 8'h00;
		neg = 1'b0;
		code = 7'h00;
		mag = 16'h0000;
		r = b;
		if (il == ol) begin
			r = b;                                            // [RL11]
		end else if (e[tct_pkg::CM_VD_BIT]) begin
			r = b ^ dataMask(il) ^ dataMask(ol);              // [RL2] [RL12]
		end else begin
			// Strip input inversion to a true code
			case (il)                                         // [RL4]
				tct_pkg::LAW_A_STD:    t = b ^ tct_pkg::MASK_EVEN;
				tct_pkg::LAW_MU_STD:   t = ~b;
				tct_pkg::LAW_A_PLAIN:  t = b;                 // [RL5]
				tct_pkg::LAW_MU_PLAIN: t = {~b[7], b[6:0]};   // [RL6]
			endcase
			neg = inMu ? t[7] : ~t[7];
			if (inMu == outMu) begin
				code = t[6:0];
			end else if (inMu) begin
				mag = muMag(t);                               // [RL19]
				code = aEnc(mag);
			end else begin
				mag = aMag(t);                                // [RL19]
				code = muEnc(mag);
			end
			// Reapply output inversion
			case (ol)                                         // [RL4] [RL19]
				tct_pkg::LAW_A_STD:    r = {~neg, code} ^ tct_pkg::MASK_EVEN;
				tct_pkg::LAW_MU_STD:   r = ~{neg, code};
				tct_pkg::LAW_A_PLAIN:  r = {~neg, code};      // [RL5]
				tct_pkg::LAW_MU_PLAIN: r = {~neg, code};      // [RL6]
			endcase
		end
		return r;
	endfunction

	// Quadrant bit replacement on one input byte
	function automatic logic [7:0] replace(input logic [7:0] b, input logic [2:0] c);
		logic [7:0] r;
		r = b;
		unique case (c)
			tct_pkg::QR_LSB0: r[0] = 1'b0;                    // [RL15]
			tct_pkg::QR_LSB1: r[0] = 1'b1;                    // [RL15]
			tct_pkg::QR_MSB0: r[7] = 1'b0;                    // [RL16]
			tct_pkg::QR_MSB1: r[7] = 1'b1;                    // [RL16]
			default:          r = b;                          // [RL15]
		endcase
		return r;
	endfunction

	assign cmEntry = cmMem[outReq.channel];

	// Connection memory upper entries, low five data bits kept
	always_ff @(posedge core_clk) begin
		if (clkEn && cmReq.wr) begin
			cmMem[cmReq.addr] <= cmReq.wrData[4:0];           // [RL18]
		end
	end

	always_comb begin
		logic [3:0] idx;
		logic [1:0] quadrant;
		logic [2:0] qcode;
		idx = 4'h0;
		quadrant = 2'h0;
		qcode = 3'h0;
		state_d = state_q;

		// Register writes and reads
		idx = regReq.addr[3:0];
		if (regReq.sel && regReq.wr && quadHit(regReq.addr)) begin
			state_d.quad[idx] = regReq.wrData[tct_pkg::QUAD_REG_W-1:0];
		end
		if (regReq.sel && !regReq.wr) begin
			if (quadHit(regReq.addr)) begin
				state_d.regRd = {4'h0, state_q.quad[idx]};
			end else begin
				state_d.regRd = 16'h0000;
			end
		end

		// Upper entry readback, upper bits zero
		if (cmReq.rd) begin
			state_d.cmRd = {11'h000, cmMem[cmReq.addr]};      // [RL18]
		end

		// Input bytes on their way into data memory
		quadrant = 2'(inReq.channel >> (4'h3 + {2'h0, inReq.rate}));          // [RL13]
		qcode = state_q.quad[inReq.stream][quadrant * tct_pkg::QUAD_FIELD_W +: tct_pkg::QUAD_FIELD_W]; // [RL14]
		state_d.inRes = inReq;
		state_d.inRes.data = replace(inReq.data, qcode);      // [RL20]

		// Output bytes, switched or message, all translated alike
		state_d.outRes = outReq;
		state_d.outRes.data = xlate(outReq.data, cmEntry);   // [RL1]
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= '0;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	assign regRdData_q = state_q.regRd;
	assign cmRdData_q  = state_q.cmRd;
	assign inRes_q     = state_q.inRes;
	assign outRes_q    = state_q.outRes;

endmodule

// ---- verif/tct_translate_props.sv ----
// Purpose: Port-level checks of the code translation block
// Assumes: Single core_clk domain, async active-high reset
// Notes:   Shadows connection memory upper entries from the write port
module tct_translate_props (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic              clkEn,
	input wire tct_pkg::tct_reg_s regReq,
	input wire logic [15:0]       regRdData_q,
	input wire tct_pkg::tct_cm_s  cmReq,
	input wire logic [15:0]       cmRdData_q,
	input wire tct_pkg::tct_in_s  inReq,
	input wire tct_pkg::tct_in_s  inRes_q,
	input wire tct_pkg::tct_out_s outReq,
	input wire tct_pkg::tct_out_s outRes_q
);
	logic       prevEn_q;
	logic [4:0] cmSh [1024];
	logic [4:0] ent;
	logic [4:0] rdEnt;
	logic [7:0] dataExp;
	function automatic logic [7:0] mk(input logic [1:0] c);
		return (c == 2'h0) ? 8'h00 : (c == 2'h1) ? 8'h55 : (c == 2'h2) ? 8'haa : 8'hff;
	endfunction
	assign ent = cmSh[outReq.channel];
	assign rdEnt = cmSh[cmReq.addr];
	assign dataExp = outReq.data ^ mk(ent[3:2]) ^ mk(ent[1:0]);
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			prevEn_q <= 1'b0;
		else
			prevEn_q <= clkEn;
	end
	always_ff @(posedge core_clk) begin
		if (clkEn && cmReq.wr)
			cmSh[cmReq.addr] <= cmReq.wrData[4:0];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	in_meta_a: assert property (prevEn_q |-> inRes_q[22:8] == $past(inReq[22:8]))
		else $error("input byte tags not carried");
	out_meta_a: assert property (prevEn_q |-> outRes_q[18:8] == $past(outReq[18:8]))
		else $error("output channel not carried");
	reg_top_a: assert property (regRdData_q[15:12] == 4'h0)
		else $error("quadrant read upper bits set");
	cm_read_a: assert property (prevEn_q && $past(cmReq.rd) |-> cmRdData_q == {11'h0, $past(rdEnt)})
		else $error("upper entry read wrong");
	unmapped_read_a: assert property (prevEn_q && $past(regReq.sel && !regReq.wr && regReq.addr[13:4] != 10'h012)
		|-> regRdData_q == 16'h0000)
		else $error("unmapped read not zero");
	freeze_out_a: assert property (!prevEn_q |-> $stable(outRes_q) && $stable(inRes_q))
		else $error("outputs moved while disabled");
	eq_law_a: assert property (prevEn_q && $past(ent[3:2] == ent[1:0]) |-> outRes_q.data == $past(outReq.data))
		else $error("equal laws changed byte");
	data_law_a: assert property (prevEn_q && $past(ent[4]) |-> outRes_q.data == $past(dataExp))
		else $error("data coding mask wrong");
	cover property (prevEn_q && $past(ent[4]));
	cover property (prevEn_q && $past(!ent[4] && ent[3:2] != ent[1:0]));
	cover property (inRes_q.valid);
endmodule

// ---- verif/tct_byte_src.sv ----
// Purpose: Input stream source sweeping one frame of channels
// Assumes: Bytes change at the falling edge
// Notes:   Released lines show inverted data
module tct_byte_src (
	input  wire logic        core_clk,
	input  wire logic        go,
	input  wire logic        gap,
	input  wire logic [3:0]  stream,
	input  wire logic [1:0]  rate,
	output tct_pkg::tct_in_s inReq
);
	timeunit 1ns;
	timeprecision 1ps;
	// Plain bytes only, no BER pattern
	initial begin
		inReq = '0;
		forever begin
			@(posedge core_clk iff go);
			for (int n = 0; n < (32 << rate); n++) begin
				@(negedge core_clk);
				inReq = {1'b1, stream, 8'(n), rate, 8'h3c ^ 8'(n)};
				if (gap) begin
					@(negedge core_clk);
					inReq.valid = 1'b0;
					inReq.data = ~inReq.data;
				end
			end
			@(negedge core_clk);
			inReq.valid = 1'b0;
			inReq.data = ~inReq.data;
		end
	end
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the code translation block
// Assumes: Inputs change at the falling edge
// Notes:   Expected bytes built from masks and quadrant codes, voice law bytes given as fixed values
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk = 1'b0;
	logic              reset = 1'b1;
	logic              clkEn = 1'b1;
	tct_pkg::tct_reg_s regReq = '0;
	tct_pkg::tct_cm_s  cmReq = 28'h8000000;
	tct_pkg::tct_in_s  inReq;
	tct_pkg::tct_in_s  inRes_q;
	tct_pkg::tct_out_s outReq = '0;
	tct_pkg::tct_out_s outRes_q;
	logic [15:0]       regRdData_q;
	logic [15:0]       cmRdData_q;
	logic              go = 1'b0;
	logic              gap = 1'b0;
	logic [3:0]        strm = 4'h0;
	logic [1:0]        rate = 2'h0;
	int                errTotal = 0;
	int                nCompared = 0;
	always #4 core_clk = ~core_clk;
	tct_byte_src i_tct_byte_src (.core_clk, .go, .gap, .stream(strm), .rate, .inReq);
	tct_translate i_tct_translate (.core_clk, .reset, .clkEn, .regReq, .regRdData_q, .cmReq, .cmRdData_q,
		.inReq, .inRes_q, .outReq, .outRes_q);
	function automatic logic [7:0] mk(input int c);
		return (c == 0) ? 8'h00 : (c == 1) ? 8'h55 : (c == 2) ? 8'haa : 8'hff;
	endfunction
	task stopTest;
		if (errTotal == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		nCompared++;
		if (g !== e) begin
			errTotal++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task regAcc(input logic w, input logic [13:0] a, input logic [15:0] d);
		regReq = {1'b1, w, a, d};
		@(negedge core_clk);
		regReq.sel = 1'b0;
		@(negedge core_clk);
	endtask
	task tRegs;
		for (int i = 0; i < 16; i++) begin
			regAcc(1'b0, 14'h0120 + 14'(i), 16'h0000);
			chk("quad reset", 16'h0000, regRdData_q);
		end
		regAcc(1'b1, 14'h012f, 16'hfabc);
		regAcc(1'b0, 14'h012f, 16'h0000);
		chk("quad rw", 16'h0abc, regRdData_q);
		regAcc(1'b1, 14'h0130, 16'h0fff);
		regAcc(1'b0, 14'h0130, 16'h0000);
		chk("unmapped", 16'h0000, regRdData_q);
		clkEn = 1'b0;
		regAcc(1'b1, 14'h0121, 16'h0fff);
		clkEn = 1'b1;
		regAcc(1'b0, 14'h0121, 16'h0000);
		chk("frozen write", 16'h0000, regRdData_q);
	endtask
	task tQuad(input logic [3:0] s, input logic [1:0] r, input logic [11:0] q, input logic g);
		logic [7:0] d;
		logic [2:0] c;
		int         n;
		n = 0;
		regAcc(1'b1, 14'h0120 + 14'(s), {4'h0, q});
		strm = s;
		rate = r;
		gap = g;
		go = 1'b1;
		@(negedge core_clk);
		go = 1'b0;
		for (int k = 0; k < 1200 && n < (32 << r); k++) begin
			@(negedge core_clk);
			if (inRes_q.valid === 1'b1) begin
				d = 8'h3c ^ 8'(n);
				c = q[3 * ((n >> (3 + r)) & 3) +: 3];
				if (c[2] && c[1])
					d[7] = c[0];
				else if (c[2])
					d[0] = c[0];
				chk("quad byte", {8'h0, d}, {8'h0, inRes_q.data});
				n++;
			end
		end
		if (n < (32 << r)) begin
			errTotal++;
			stopTest;
		end
	endtask
	task tOut(input logic [4:0] e, input logic [7:0] d, input logic [7:0] x);
		cmReq = {1'b1, 1'b0, 10'h155, 11'h7ff, e};
		@(negedge core_clk);
		cmReq = {1'b0, 1'b1, 10'h155, 16'h0000};
		outReq = {1'b1, 10'h155, d};
		@(negedge core_clk);
		chk("law byte", {8'h0, x}, {8'h0, outRes_q.data});
		chk("entry read", {11'h0, e}, cmRdData_q);
		cmReq.rd = 1'b0;
		outReq.valid = 1'b0;
		@(negedge core_clk);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		reset = 1'b0;
		cmReq = '0;
		tRegs;
		for (int r = 0; r < 4; r++)
			tQuad(4'(r + 3), 2'(r), 12'hfac, 1'b0);
		tQuad(4'h0, 2'h1, 12'h611, 1'b1);
		for (int i = 0; i < 4; i++)
			for (int o = 0; o < 4; o++)
				tOut({1'b1, 2'(i), 2'(o)}, 8'h96, 8'h96 ^ mk(i) ^ mk(o));
		tOut(5'b0_00_10, 8'hd5, 8'h80);
		tOut(5'b0_01_11, 8'hff, 8'h80);
		tOut(5'b0_01_00, 8'hff, 8'hd5);
		tOut(5'b0_11_00, 8'h80, 8'hd5);
		tOut(5'b0_00_01, 8'hd5, 8'hfe);
		tOut(5'b0_10_11, 8'h80, 8'h81);
		tOut(5'b0_01_01, 8'h3a, 8'h3a);
		stopTest;
	end
endmodule
bind tct_translate tct_translate_props i_tct_translate_props (.core_clk, .reset, .clkEn, .regReq, .regRdData_q,
	.cmReq, .cmRdData_q, .inReq, .inRes_q, .outReq, .outRes_q);
